/* hdl/urxs_rx_status.v */
// Purpose: Receive status flags, four-buffer ring and request flags.
// Assumes: Receive shifter and transmitter run on ref_clk and give pulses.
// Notes: Registers are reached over AXI4-Lite, one word per register.
`timescale 1ns/1ps
`include "urxs_consts.vh"

module urxs_rx_status
(
    input wire ref_clk,
    input wire arst_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire rx_done,
    input wire [7:0] rx_data,
    input wire rx_parity_bit,
    input wire rx_stop_bit,
    input wire addr_marker_bit,
    input wire tx_ready_evt,
    output wire rx_irq,
    output wire tx_irq
);

////////////////////////////////////////////////////////////////////////////
reg awready_ff;
reg wready_ff;
reg bvalid_ff;
reg [1:0] bresp_ff;
reg arready_ff;
reg rvalid_ff;
reg [1:0] rresp_ff;
reg [31:0] rdata_ff;
reg aw_got_ff;
reg w_got_ff;
reg [7:0] wr_addr_ff;
reg [7:0] wr_data_ff;
reg wr_lane0_ff;
reg [7:0] cfg_ff;
reg rv_ie0_ff;
reg tr_ie_ff;
reg tr_irq_ff;
reg frame_err_flag_ff;
reg [3:1] rv_ie_ff;
reg [1:0] ring_cnt_ff;
reg [3:0] overrun_ff;
reg [3:0] parity_err_ff;
reg [3:0] mproc_err_ff;
reg [3:0] pending_ff;
reg [3:0] unread_ff;
reg [7:0] rx_buf_ff [0:3];
reg rx_irq_ff;
reg tx_irq_ff;

wire aw_take;
wire w_take;
wire ar_take;
wire wr_go;
wire wr_en;
wire sel_s0;
wire sel_s1;
wire sel_s2;
wire sel_ic;
wire sel_cfg;
wire wr_mapped;
wire four_stage_select;
wire rx_addr_select;
wire mproc_mode;
wire parity_en;
wire parity_even;
wire rx_take;
wire [1:0] tgt;
wire ev_perr;
wire ev_merr;
wire [3:0] ld;
wire [3:0] rd_clr;
wire [3:0] clr_o;
wire [3:0] clr_p;
wire [3:0] clr_m;
wire [3:0] clr_r;
wire clr_ferr;
wire [3:0] ie_all;
reg [7:0] rd_byte;
reg rd_ok;

assign s_axi_awready = awready_ff;
assign s_axi_wready = wready_ff;
assign s_axi_bvalid = bvalid_ff;
assign s_axi_bresp = bresp_ff;
assign s_axi_arready = arready_ff;
assign s_axi_rvalid = rvalid_ff;
assign s_axi_rresp = rresp_ff;
assign s_axi_rdata = rdata_ff;
assign rx_irq = rx_irq_ff;
assign tx_irq = tx_irq_ff;

////////////////////////////////////////////////////////////////////////////
// Write address and data are caught independently; the write acts once
// both are held and no response is outstanding.
assign aw_take = s_axi_awvalid & awready_ff;
assign w_take = s_axi_wvalid & wready_ff;
assign ar_take = s_axi_arvalid & arready_ff;
assign wr_go = aw_got_ff & w_got_ff & ~bvalid_ff;
assign wr_en = wr_go & wr_lane0_ff;
assign sel_s0 = wr_en & (wr_addr_ff == `URXS_OFS_STAT0);
assign sel_s1 = wr_en & (wr_addr_ff == `URXS_OFS_STAT1);
assign sel_s2 = wr_en & (wr_addr_ff == `URXS_OFS_STAT2);
assign sel_ic = wr_en & (wr_addr_ff == `URXS_OFS_IRQCTL);
assign sel_cfg = wr_en & (wr_addr_ff == `URXS_OFS_CFG);
assign wr_mapped = (wr_addr_ff == `URXS_OFS_STAT0) |
                   (wr_addr_ff == `URXS_OFS_STAT1) |
                   (wr_addr_ff == `URXS_OFS_STAT2) |
                   (wr_addr_ff == `URXS_OFS_IRQCTL) |
                   (wr_addr_ff == `URXS_OFS_CFG) |
                   (wr_addr_ff == `URXS_OFS_BUF0) |
                   (wr_addr_ff == `URXS_OFS_BUF1) |
                   (wr_addr_ff == `URXS_OFS_BUF2) |
                   (wr_addr_ff == `URXS_OFS_BUF3);

always @(posedge ref_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        awready_ff <= 1'b0;
        wready_ff <= 1'b0;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        wr_addr_ff <= 8'h00;
        wr_data_ff <= 8'h00;
        wr_lane0_ff <= 1'b0;
        bvalid_ff <= 1'b0;
        bresp_ff <= `URXS_RESP_OKAY;
    end
    else
    begin
        if (aw_take)
        begin
            aw_got_ff <= 1'b1;
            wr_addr_ff <= s_axi_awaddr;
            awready_ff <= 1'b0;
        end
        else if (wr_go)
            aw_got_ff <= 1'b0;
        else if (!aw_got_ff && !bvalid_ff)
            awready_ff <= 1'b1;
        if (w_take)
        begin
            w_got_ff <= 1'b1;
            wr_data_ff <= s_axi_wdata[7:0];
            wr_lane0_ff <= s_axi_wstrb[0];
            wready_ff <= 1'b0;
        end
        else if (wr_go)
            w_got_ff <= 1'b0;
        else if (!w_got_ff && !bvalid_ff)
            wready_ff <= 1'b1;
        // A refused address still gets its response, so no master hangs.
        if (wr_go)
        begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_mapped ? `URXS_RESP_OKAY : `URXS_RESP_SLVERR;
        end
        else if (bvalid_ff && s_axi_bready)
            bvalid_ff <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////
// Read data is captured at the address handshake, so a buffer read clears
// its unread mark in that same cycle.
always @*
begin
    rd_byte = 8'hFF;
    rd_ok = 1'b1;
    case (s_axi_araddr)
        `URXS_OFS_STAT0:
            rd_byte = {tr_irq_ff, tr_ie_ff, pending_ff[0], rv_ie0_ff,
                       mproc_err_ff[0], parity_err_ff[0], overrun_ff[0],
                       frame_err_flag_ff};
        `URXS_OFS_STAT1:
            rd_byte = {mproc_err_ff[2], parity_err_ff[2], overrun_ff[2],
                       1'b1, mproc_err_ff[1], parity_err_ff[1],
                       overrun_ff[1], 1'b1};
        `URXS_OFS_STAT2:
            rd_byte = {2'b11, ring_cnt_ff, mproc_err_ff[3],
                       parity_err_ff[3], overrun_ff[3], 1'b1};
        `URXS_OFS_IRQCTL:
            rd_byte = {pending_ff[3:1], pending_ff[0], rv_ie_ff,
                       1'b1};
        `URXS_OFS_CFG:
            rd_byte = cfg_ff;
        `URXS_OFS_BUF0:
            rd_byte = rx_buf_ff[0];
        `URXS_OFS_BUF1:
            rd_byte = rx_buf_ff[1];
        `URXS_OFS_BUF2:
            rd_byte = rx_buf_ff[2];
        `URXS_OFS_BUF3:
            rd_byte = rx_buf_ff[3];
        default:
        begin
            // Unmapped words answer with zero data and an error response.
            rd_byte = 8'h00;
            rd_ok = 1'b0;
        end
    endcase
end

always @(posedge ref_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b0;
        rresp_ff <= `URXS_RESP_OKAY;
        rdata_ff <= 32'h0000_0000;
    end
    else
    begin
        if (ar_take)
        begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= {24'h00_0000, rd_byte};
            rresp_ff <= rd_ok ? `URXS_RESP_OKAY : `URXS_RESP_SLVERR;
        end
        else if (rvalid_ff && s_axi_rready)
            rvalid_ff <= 1'b0;
        else if (!rvalid_ff)
            arready_ff <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////
// Configuration stands in for the receive control bits this block needs.
assign mproc_mode = cfg_ff[`URXS_BIT_MPMODE];
assign rx_addr_select = cfg_ff[`URXS_BIT_ADDRSEL];
assign four_stage_select = cfg_ff[`URXS_BIT_FOURSTG];
assign parity_en = cfg_ff[`URXS_BIT_PAREN];
assign parity_even = cfg_ff[`URXS_BIT_PAREVN];

// In address-receive mode a data frame is ignored: no load, no request.
assign rx_take = rx_done & ~(mproc_mode & rx_addr_select & ~addr_marker_bit);
assign tgt = four_stage_select ? ring_cnt_ff : 2'b00;
assign ev_perr = parity_en &
                 (^rx_data ^ rx_parity_bit ^ ~parity_even);
assign ev_merr = mproc_mode & ~rx_addr_select &
                 addr_marker_bit;

assign clr_ferr = sel_s0 & ~wr_data_ff[`URXS_BIT_FERR];
assign clr_o = {sel_s2 & ~wr_data_ff[`URXS_BIT_OERR_LO],
                sel_s1 & ~wr_data_ff[`URXS_BIT_OERR_HI],
                sel_s1 & ~wr_data_ff[`URXS_BIT_OERR_LO],
                sel_s0 & ~wr_data_ff[`URXS_BIT_OERR_LO]};
assign clr_p = {sel_s2 & ~wr_data_ff[`URXS_BIT_PERR_LO],
                sel_s1 & ~wr_data_ff[`URXS_BIT_PERR_HI],
                sel_s1 & ~wr_data_ff[`URXS_BIT_PERR_LO],
                sel_s0 & ~wr_data_ff[`URXS_BIT_PERR_LO]};
assign clr_m = {sel_s2 & ~wr_data_ff[`URXS_BIT_MERR_LO],
                sel_s1 & ~wr_data_ff[`URXS_BIT_MERR_HI],
                sel_s1 & ~wr_data_ff[`URXS_BIT_MERR_LO],
                sel_s0 & ~wr_data_ff[`URXS_BIT_MERR_LO]};
// Buffer-0 pending clears only through status 0; the mirror is ignored.
assign clr_r = {sel_ic & ~wr_data_ff[`URXS_BIT_RVIRQ3],
                sel_ic & ~wr_data_ff[`URXS_BIT_RVIRQ2],
                sel_ic & ~wr_data_ff[`URXS_BIT_RVIRQ1],
                sel_s0 & ~wr_data_ff[`URXS_BIT_RVIRQ0]};

////////////////////////////////////////////////////////////////////////////
// Per-buffer state: a set in the same cycle as a clear always wins.
genvar gi;
generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_buf
        // A genvar cannot be sliced, so each buffer gets its index and
        // read offset as constants of the width they are compared at.
        localparam integer BUF_N = gi;
        localparam [1:0] BUF_IDX = BUF_N[1:0];
        localparam [7:0] BUF_OFS = `URXS_OFS_BUF0 + {4'h0, BUF_IDX, 2'b00};
        assign ld[gi] = rx_take & (tgt == BUF_IDX);
        assign rd_clr[gi] = ar_take &
            (s_axi_araddr == BUF_OFS);
        always @(posedge ref_clk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                overrun_ff[gi] <= 1'b0;
                parity_err_ff[gi] <= 1'b0;
                mproc_err_ff[gi] <= 1'b0;
                pending_ff[gi] <= 1'b0;
                unread_ff[gi] <= 1'b0;
            end
            else
            begin
                overrun_ff[gi] <= (overrun_ff[gi] & ~clr_o[gi]) |
                    (ld[gi] & unread_ff[gi]);
                parity_err_ff[gi] <= (parity_err_ff[gi] & ~clr_p[gi]) |
                    (ld[gi] & ev_perr);
                mproc_err_ff[gi] <= (mproc_err_ff[gi] & ~clr_m[gi]) |
                    (ld[gi] & ev_merr);
                pending_ff[gi] <= (pending_ff[gi] & ~clr_r[gi]) |
                    ld[gi];
                unread_ff[gi] <= (unread_ff[gi] & ~rd_clr[gi]) |
                    ld[gi];
            end
        end
        // Data buffers carry no reset; their content is undefined until
        // the first byte lands.
        always @(posedge ref_clk)
        begin
            if (ld[gi])
                rx_buf_ff[gi] <= rx_data;
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////
assign ie_all = {rv_ie_ff, rv_ie0_ff};

always @(posedge ref_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        cfg_ff <= `URXS_RST_CFG;
        rv_ie0_ff <= 1'b0;
        tr_ie_ff <= 1'b0;
        tr_irq_ff <= 1'b0;
        frame_err_flag_ff <= 1'b0;
        rv_ie_ff <= 3'b000;
        ring_cnt_ff <= 2'b00;
        rx_irq_ff <= 1'b0;
        tx_irq_ff <= 1'b0;
    end
    else
    begin
        if (sel_cfg)
            cfg_ff <= wr_data_ff;
        if (sel_s0)
        begin
            rv_ie0_ff <= wr_data_ff[`URXS_BIT_RVIE0];
            tr_ie_ff <= wr_data_ff[`URXS_BIT_TRIE];
        end
        if (sel_ic)
            rv_ie_ff <= {wr_data_ff[`URXS_BIT_RVIE3],
                         wr_data_ff[`URXS_BIT_RVIE2],
                         wr_data_ff[`URXS_BIT_RVIE1]};
        // A transmit event in the cycle of a clear keeps the flag set.
        tr_irq_ff <= (tr_irq_ff &
            ~(sel_s0 & ~wr_data_ff[`URXS_BIT_TRIRQ])) | tx_ready_evt;
        frame_err_flag_ff <= (frame_err_flag_ff & ~clr_ferr) |
            (rx_take & ~rx_stop_bit);
        // The counter only moves in ring mode; writes never reach it.
        if (rx_take && four_stage_select)
            ring_cnt_ff <= ring_cnt_ff + 2'b01;
        rx_irq_ff <= |(pending_ff & ie_all);
        tx_irq_ff <= tr_irq_ff & tr_ie_ff;
    end
end

endmodule

/* hdl/urxs_consts.vh */
// Purpose: Constants of the serial receive status and ring flag block.
// Assumes: AXI4-Lite register access, 32-bit data, 8-bit registers.
// Notes: Offsets are byte addresses; registers sit in the low byte.
`ifndef URXS_CONSTS_VH
`define URXS_CONSTS_VH

`define URXS_OFS_STAT0 8'h00
`define URXS_OFS_STAT1 8'h04
`define URXS_OFS_STAT2 8'h08
`define URXS_OFS_IRQCTL 8'h0C
`define URXS_OFS_CFG 8'h10
`define URXS_OFS_BUF0 8'h14
`define URXS_OFS_BUF1 8'h18
`define URXS_OFS_BUF2 8'h1C
`define URXS_OFS_BUF3 8'h20

`define URXS_RST_STAT0 8'h00
`define URXS_RST_STAT1 8'h11
`define URXS_RST_STAT2 8'hC1
`define URXS_RST_IRQCTL 8'h01
`define URXS_RST_CFG 8'h00

`define URXS_BIT_FERR 0
`define URXS_BIT_OERR_LO 1
`define URXS_BIT_PERR_LO 2
`define URXS_BIT_MERR_LO 3
`define URXS_BIT_RVIE0 4
`define URXS_BIT_RVIRQ0 5
`define URXS_BIT_TRIE 6
`define URXS_BIT_TRIRQ 7
`define URXS_BIT_OERR_HI 5
`define URXS_BIT_PERR_HI 6
`define URXS_BIT_MERR_HI 7
`define URXS_BIT_CNT_LSB 4
`define URXS_BIT_CNT_MSB 5
`define URXS_BIT_MIRROR0 4
`define URXS_BIT_RVIE1 1
`define URXS_BIT_RVIE2 2
`define URXS_BIT_RVIE3 3
`define URXS_BIT_RVIRQ1 5
`define URXS_BIT_RVIRQ2 6
`define URXS_BIT_RVIRQ3 7

`define URXS_BIT_MPMODE 0
`define URXS_BIT_ADDRSEL 2
`define URXS_BIT_FOURSTG 3
`define URXS_BIT_PAREN 5
`define URXS_BIT_PAREVN 6

`define URXS_RESP_OKAY 2'b00
`define URXS_RESP_SLVERR 2'b10

`endif

/* test/urxs_rx_status_chk.sv */
// Purpose: Port checker for the receive status block.
// Assumes: One clock domain and an asynchronous active-low reset.
// Notes: Enables are internal, so request edges are tied to their causes.
`timescale 1ns/1ps
module urxs_rx_status_chk
(
    input wire ref_clk,
    input wire arst_n,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire rx_done,
    input wire tx_ready_evt,
    input wire rx_irq,
    input wire tx_irq
);
default clocking cb @(posedge ref_clk);
endclocking
default disable iff (!arst_n);
////////////////////////////////////////////////////////////////////////////
sequence ar_take;
    s_axi_arvalid && s_axi_arready;
endsequence
sequence aw_take;
    s_axi_awvalid && s_axi_awready;
endsequence
////////////////////////////////////////////////////////////////////////////
AST_RD_ANSWER: assert property (ar_take |=> s_axi_rvalid)
    else $error("read answer late");
AST_RD_UNMAPPED: assert property (ar_take ##0 (s_axi_araddr > 8'h20 ||
    s_axi_araddr[1:0] != 2'b00)
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
AST_RD_BYTE: assert property (ar_take ##0 (s_axi_araddr <= 8'h20 &&
    s_axi_araddr[1:0] == 2'b00) |=>
    s_axi_rresp == 2'b00 && s_axi_rdata[31:8] == 24'h0)
    else $error("mapped read malformed");
AST_WR_ANSWER: assert property (aw_take |-> ##[1:4] s_axi_bvalid)
    else $error("write answer late");
AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer open");
AST_RX_RISE: assert property ($rose(rx_irq) |->
    $past(rx_done, 2) || $past(s_axi_bvalid))
    else $error("receive request without cause");
AST_TX_RISE: assert property ($rose(tx_irq) |->
    $past(tx_ready_evt, 2) || $past(s_axi_bvalid))
    else $error("transmit request without cause");
AST_RX_FALL: assert property ($fell(rx_irq) |-> $past(s_axi_bvalid))
    else $error("receive request cleared by itself");
AST_TX_FALL: assert property ($fell(tx_irq) |-> $past(s_axi_bvalid))
    else $error("transmit request cleared by itself");
endmodule
bind urxs_rx_status urxs_rx_status_chk i_urxs_rx_status_chk
(
    .ref_clk(ref_clk), .arst_n(arst_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .rx_done(rx_done),
    .tx_ready_evt(tx_ready_evt), .rx_irq(rx_irq), .tx_irq(tx_irq)
);

/* test/urxs_remote_tx.sv */
// Purpose: Far-end transmitter as seen through the receive shifter.
// Assumes: One character strobe per call, on ref_clk.
// Notes: Lines carry inverted data outside a strobe, so stale values show.
`timescale 1ns/1ps
module urxs_remote_tx
(
    input wire ref_clk,
    input wire par_even,
    output logic rx_done = 1'b0,
    output logic [7:0] rx_data = 8'h00,
    output logic rx_parity_bit = 1'b0,
    output logic rx_stop_bit = 1'b1,
    output logic addr_marker_bit = 1'b0
);
// A bad parity flag inverts the sense chosen by par_even.
task automatic send(input logic [7:0] d, input logic bad,
    input logic stop, input logic mark);
    begin
        @(posedge ref_clk);
        rx_done <= 1'b1;
        rx_data <= d;
        rx_parity_bit <= (^d) ^ ~par_even ^ bad;
        rx_stop_bit <= stop;
        addr_marker_bit <= mark;
        @(posedge ref_clk);
        rx_done <= 1'b0;
        rx_data <= ~d;
        rx_parity_bit <= ~rx_parity_bit;
        rx_stop_bit <= ~stop;
        addr_marker_bit <= ~mark;
    end
endtask
endmodule

/* test/urxs_rx_status_test.sv */
// Purpose: Self-checking bench of the receive status block.
// Assumes: One register access at a time; enables off in ring mode.
// Notes: Requests are judged after a read, once their register settled.
`timescale 1ns/1ps
module urxs_rx_status_test;
logic ref_clk, arst_n, aw_v, w_v, b_r, ar_v, r_r, tx_evt, par_even;
logic [7:0] awaddr, araddr;
logic [31:0] wdata, d;
logic [1:0] wresp;
logic [7:0] rst_tab [0:4] = '{8'h00, 8'h11, 8'hC1, 8'h01, 8'h00};
wire awready, wready, bvalid, arready, rvalid, rx_irq, tx_irq;
wire rx_done, rx_par, rx_stop, mark;
wire [1:0] bresp, rresp;
wire [31:0] rdata;
wire [7:0] rx_data;
int n_fail = 0;
int cmp_count = 0;
urxs_rx_status i_urxs_rx_status
(
    .ref_clk(ref_clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(aw_v), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(b_r),
    .s_axi_araddr(araddr), .s_axi_arvalid(ar_v), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(r_r), .rx_done(rx_done), .rx_data(rx_data),
    .rx_parity_bit(rx_par), .rx_stop_bit(rx_stop),
    .addr_marker_bit(mark), .tx_ready_evt(tx_evt), .rx_irq(rx_irq),
    .tx_irq(tx_irq)
);
urxs_remote_tx i_urxs_remote_tx
(
    .ref_clk(ref_clk), .par_even(par_even), .rx_done(rx_done),
    .rx_data(rx_data), .rx_parity_bit(rx_par), .rx_stop_bit(rx_stop),
    .addr_marker_bit(mark)
);
initial
begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
end
////////////////////////////////////////////////////////////////////////////
task automatic conclude;
    begin
        $display("Compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    end
endtask
// Each access waits one idle edge at its end so no signal is driven twice.
task automatic wr(input logic [7:0] a, input logic [7:0] v);
    bit ok;
    begin
        ok = 0;
        awaddr <= a;
        wdata <= {24'h0, v};
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= 1'b1;
        for (int n = 0; n < 20 && !ok; n++)
        begin
            @(posedge ref_clk);
            if (aw_v && awready) aw_v <= 1'b0;
            if (w_v && wready) w_v <= 1'b0;
            if (bvalid) b_r <= 1'b0;
            if (bvalid) wresp = bresp;
            ok = bvalid;
        end
        if (!ok) chk(32'h0, 32'h1);
        if (!ok) conclude;
        @(posedge ref_clk);
    end
endtask
task automatic rd(input logic [7:0] a);
    bit ok;
    begin
        ok = 0;
        araddr <= a;
        ar_v <= 1'b1;
        r_r <= 1'b1;
        for (int n = 0; n < 20 && !ok; n++)
        begin
            @(posedge ref_clk);
            if (ar_v && arready) ar_v <= 1'b0;
            if (rvalid) r_r <= 1'b0;
            d = {rdata[31:2], rdata[1:0] | rresp};
            ok = rvalid;
        end
        if (!ok) chk(32'h0, 32'h1);
        if (!ok) conclude;
        @(posedge ref_clk);
    end
endtask
// A non-OKAY response shows up as a mismatch in the two low bits.
task automatic rd_chk(input logic [7:0] a, input logic [7:0] m,
    input logic [7:0] e);
    begin
        rd(a);
        chk(d & {24'hFFFFFF, m}, {24'h0, e});
    end
endtask
task automatic do_reset;
    begin
        @(posedge ref_clk);
        arst_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
    end
endtask
task automatic tx_pulse;
    begin
        @(posedge ref_clk);
        tx_evt <= 1'b1;
        @(posedge ref_clk);
        tx_evt <= 1'b0;
    end
endtask
////////////////////////////////////////////////////////////////////////////
task automatic t_reset_vals;
    begin
        for (int i = 0; i < 5; i++)
            rd_chk(8'h04 * i[7:0], 8'hFF, rst_tab[i]);
        rd(8'h24);
        chk(d, 32'h2);
        wr(8'h24, 8'h00);
        chk({30'h0, wresp}, 32'h2);
    end
endtask
task automatic t_single;
    begin
        wr(8'h10, 8'h60);
        chk({30'h0, wresp}, 32'h0);
        wr(8'h00, 8'h50);
        i_urxs_remote_tx.send(8'hA5, 1'b1, 1'b0, 1'b0);
        rd_chk(8'h00, 8'hFF, 8'h75);
        chk({31'h0, rx_irq}, 32'h1);
        i_urxs_remote_tx.send(8'h3C, 1'b0, 1'b1, 1'b0);
        rd_chk(8'h00, 8'hFF, 8'h77);
        wr(8'h00, 8'h50);
        i_urxs_remote_tx.send(8'h5A, 1'b0, 1'b1, 1'b0);
        rd_chk(8'h00, 8'hFF, 8'h72);
        rd_chk(8'h14, 8'hFF, 8'h5A);
        wr(8'h00, 8'h50);
        rd_chk(8'h00, 8'hFF, 8'h50);
        chk({31'h0, rx_irq}, 32'h0);
        wr(8'h00, 8'h40);
        i_urxs_remote_tx.send(8'hC3, 1'b0, 1'b1, 1'b0);
        tx_pulse;
        rd_chk(8'h00, 8'hFF, 8'hE0);
        chk({30'h0, rx_irq, tx_irq}, 32'h1);
        wr(8'h00, 8'h00);
        tx_pulse;
        wr(8'h10, 8'h01);
        i_urxs_remote_tx.send(8'h11, 1'b0, 1'b1, 1'b1);
        rd_chk(8'h00, 8'hFF, 8'hAA);
        chk({30'h0, rx_irq, tx_irq}, 32'h0);
    end
endtask
// Ring pass one carries errors into buffers 1 to 3, pass two overruns all.
task automatic t_ring;
    begin
        wr(8'h10, 8'h69);
        for (int i = 0; i < 8; i++)
        begin
            i_urxs_remote_tx.send(8'h40 + i[7:0], i == 1 || i == 3,
                i != 2, i == 2 || i == 3);
            rd_chk(8'h08, 8'h30, {2'b00, i[1:0] + 2'b01, 4'h0});
            if (i == 3)
            begin
                rd_chk(8'h04, 8'hFF, 8'h95);
                rd_chk(8'h08, 8'hFF, 8'hCD);
                rd_chk(8'h00, 8'hFF, 8'h21);
                rd_chk(8'h0C, 8'hFF, 8'hF1);
            end
        end
        rd_chk(8'h04, 8'hFF, 8'hB7);
        rd_chk(8'h08, 8'hFF, 8'hCF);
        rd_chk(8'h00, 8'hFF, 8'h23);
        wr(8'h08, 8'h30);
        rd_chk(8'h08, 8'hFF, 8'hC1);
        wr(8'h0C, 8'h00);
        rd_chk(8'h0C, 8'hFF, 8'h11);
        rd_chk(8'h18, 8'hFF, 8'h45);
        rd_chk(8'h1C, 8'hFF, 8'h46);
        rd_chk(8'h20, 8'hFF, 8'h47);
        i_urxs_remote_tx.send(8'h77, 1'b0, 1'b1, 1'b0);
        wr(8'h10, 8'h00);
        i_urxs_remote_tx.send(8'h99, 1'b0, 1'b1, 1'b0);
        rd_chk(8'h14, 8'hFF, 8'h99);
        rd_chk(8'h08, 8'h30, 8'h10);
    end
endtask
// Odd parity and address receive: a data frame is dropped, an address lands.
task automatic t_modes;
    begin
        par_even <= 1'b0;
        wr(8'h00, 8'h00);
        wr(8'h10, 8'h25);
        i_urxs_remote_tx.send(8'h66, 1'b0, 1'b1, 1'b0);
        rd_chk(8'h00, 8'hFF, 8'h00);
        i_urxs_remote_tx.send(8'h81, 1'b1, 1'b1, 1'b1);
        rd_chk(8'h00, 8'hFF, 8'h24);
        rd_chk(8'h14, 8'hFF, 8'h81);
        wr(8'h00, 8'h00);
        i_urxs_remote_tx.send(8'h3C, 1'b0, 1'b1, 1'b1);
        rd_chk(8'h00, 8'hFF, 8'h20);
    end
endtask
////////////////////////////////////////////////////////////////////////////
initial
begin
    arst_n = 1'b0;
    {aw_v, w_v, b_r, ar_v, r_r, tx_evt} = 6'h00;
    par_even = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wresp = 2'b00;
    do_reset;
    t_reset_vals;
    t_single;
    do_reset;
    t_ring;
    t_modes;
    conclude;
end
endmodule
